// file: rtl/asn_neuron.sv
// leaky integrate-and-fire neuron with adaptive threshold, top level
`timescale 1ns/1ps
`default_nettype none
module asn_neuron
  import asn_pkg::*;
(
  input wire logic core_clk, // 40 MHz system clock
  input wire logic srst, // synchronous reset, active high
  input wire logic [CUR_W-1:0] neuron_current_in, // input current pins
  input wire logic [PIN_W-1:0] bidir_in, // bidirectional pin levels in
  output logic [PIN_W-1:0] dedicated_out, // refractory flag and potential
  output logic [PIN_W-1:0] bidir_out, // spike and spike count
  output logic [PIN_W-1:0] bidir_oe // output enables, high drives
);
  logic [CUR_W:0] pins_sync;
  logic [CUR_W-1:0] current;
  logic learn_en;
  logic [POT_W-1:0] threshold;
  logic [POT_W-1:0] pot_reg;
  logic [POT_W-1:0] pot_next;
  logic [POT_W-1:0] leak;
  logic [POT_W-1:0] integrated;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic [REFR_W-1:0] refr_cnt_reg;
  logic [REFR_W-1:0] refr_cnt_next;
  asn_state_t state_reg;
  asn_state_t state_next;
  logic spike_fire;
  logic refr_next;

  // current and learning bit come from pins, so both are synchronised
  asn_sync #(
    .WIDTH(CUR_W + 1)
  ) u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .async_in({bidir_in[LEARN_BIT], neuron_current_in}),
    .sync_out(pins_sync)
  );
  assign current = pins_sync[CUR_W-1:0];
  assign learn_en = pins_sync[CUR_W];

  asn_threshold u_thresh (
    .core_clk(core_clk),
    .srst(srst),
    .learn_en(learn_en),
    .spike_fire(spike_fire),
    .threshold(threshold)
  );

  // leak then integrate; worst case 4095-1023+255 fits twelve bits, no saturation needed
  assign leak = pot_reg >> LEAK_SHIFT;
  assign integrated = pot_reg - leak + POT_W'(current);
  assign spike_fire = (state_reg == ASN_ST_RUN) && (integrated >= threshold);

  // potential stays at zero through refractory so input is ignored there
  assign pot_next = (spike_fire || state_reg == ASN_ST_REFR) ? POT_RESET : integrated;
  assign count_next = spike_fire ? count_reg + 7'h01 : count_reg;

  // refractory sequencing: three cycles after the spike cycle
  always_comb
  begin
    state_next = state_reg;
    refr_cnt_next = refr_cnt_reg;
    case (state_reg)
      ASN_ST_RUN:
      begin
        if (spike_fire)
        begin
          state_next = ASN_ST_REFR;
          refr_cnt_next = REFR_CYCLES;
        end
      end
      ASN_ST_REFR:
      begin
        refr_cnt_next = refr_cnt_reg - REFR_LAST;
        if (refr_cnt_reg == REFR_LAST)
          state_next = ASN_ST_RUN;
      end
      default:
      begin
        state_next = ASN_ST_RUN;
        refr_cnt_next = '0;
      end
    endcase
  end
  assign refr_next = (state_next == ASN_ST_REFR);

  // neuron state registers
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      pot_reg <= POT_RESET;
      count_reg <= CNT_RESET;
      state_reg <= ASN_ST_RUN;
      refr_cnt_reg <= '0;
    end
    else
    begin
      pot_reg <= pot_next;
      count_reg <= count_next;
      state_reg <= state_next;
      refr_cnt_reg <= refr_cnt_next;
    end
  end

  // outputs are registered copies of the next state, so they line up with the state flops
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      dedicated_out <= OUT_RESET;
      bidir_out <= OUT_RESET;
    end
    else
    begin
      dedicated_out[REFR_BIT] <= refr_next;
      dedicated_out[REFR_BIT-1:0] <= pot_next[REFR_BIT-1:0];
      bidir_out[SPIKE_BIT] <= spike_fire;
      bidir_out[SPIKE_BIT-1:0] <= count_next;
    end
  end

  // enables are fixed; bit 0 is never driven so the learning bit stays an input
  always_ff @(posedge core_clk)
  begin
    bidir_oe <= OE_VALUE;
  end
endmodule
`default_nettype wire

// file: rtl/asn_pkg.sv
// constants shared by the adaptive spiking neuron files
package asn_pkg;
  localparam int POT_W = 12;
  localparam int CUR_W = 8;
  localparam int CNT_W = 7;
  localparam int ADAPT_W = 8;
  localparam int PIN_W = 8;
  localparam int REFR_W = 2;
  localparam int LEARN_BIT = 0;
  localparam int REFR_BIT = 7;
  localparam int SPIKE_BIT = 7;
  localparam int LEAK_SHIFT = 2;
  localparam logic [POT_W-1:0] BASE_THRESH = 12'h064;
  localparam logic [POT_W-1:0] POT_RESET = 12'h000;
  localparam logic [ADAPT_W-1:0] ADAPT_RESET = 8'h00;
  localparam logic [ADAPT_W-1:0] ADAPT_STEP = 8'h04;
  localparam logic [ADAPT_W-1:0] ADAPT_DECAY = 8'h01;
  localparam logic [CNT_W-1:0] CNT_RESET = 7'h00;
  localparam logic [REFR_W-1:0] REFR_CYCLES = 2'h3;
  localparam logic [REFR_W-1:0] REFR_LAST = 2'h1;
  localparam logic [PIN_W-1:0] OE_VALUE = 8'hFE;
  localparam logic [PIN_W-1:0] OUT_RESET = 8'h00;
  typedef enum logic {ASN_ST_RUN, ASN_ST_REFR} asn_state_t;
endpackage

// file: rtl/asn_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module asn_sync #(
  parameter int WIDTH = 9
) (
  input wire logic core_clk, // system clock
  input wire logic srst, // synchronous reset, active high
  input wire logic [WIDTH-1:0] async_in, // raw pin levels
  output logic [WIDTH-1:0] sync_out // levels after two flops
);
  logic [WIDTH-1:0] stage1_reg;

  // first stage feeds only the second stage, to contain metastability
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      stage1_reg <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end
endmodule
`default_nettype wire

// file: rtl/asn_threshold.sv
// adaptive firing threshold: base plus a learned component
`timescale 1ns/1ps
`default_nettype none
module asn_threshold
  import asn_pkg::*;
#(
  parameter int AW = ADAPT_W
) (
  input wire logic core_clk, // system clock
  input wire logic srst, // synchronous reset, active high
  input wire logic learn_en, // synchronised learning enable
  input wire logic spike_fire, // spike decided this cycle
  output logic [POT_W-1:0] threshold // threshold in force this cycle
);
  logic [AW-1:0] adapt_reg;
  logic [AW-1:0] adapt_next;
  logic [AW-1:0] adapt_up;
  logic [AW-1:0] adapt_down;
  logic at_top;
  logic at_floor;

  // saturating steps so the threshold never wraps back to base
  assign at_top = (adapt_reg > ({AW{1'b1}} - AW'(ADAPT_STEP)));
  assign at_floor = (adapt_reg < AW'(ADAPT_DECAY));
  assign adapt_up = at_top ? {AW{1'b1}} : adapt_reg + AW'(ADAPT_STEP);
  assign adapt_down = at_floor ? '0 : adapt_reg - AW'(ADAPT_DECAY);
  assign adapt_next = !learn_en ? adapt_reg : (spike_fire ? adapt_up : adapt_down);
  assign threshold = BASE_THRESH + POT_W'(adapt_reg);

  // adaptation state clears with reset, putting threshold at base
  always_ff @(posedge core_clk)
  begin
    if (srst)
      adapt_reg <= AW'(ADAPT_RESET);
    else
      adapt_reg <= adapt_next;
  end
endmodule
`default_nettype wire

// file: tb/asn_checker.sv
// pin-level assertions for the neuron
`timescale 1ns/1ps
`default_nettype none
module asn_checker
  import asn_pkg::*;
(
  input wire logic core_clk, // clock
  input wire logic srst, // reset
  input wire logic [CUR_W-1:0] neuron_current_in, // current
  input wire logic [PIN_W-1:0] bidir_in, // pin levels
  input wire logic [PIN_W-1:0] dedicated_out, // refr, potential
  input wire logic [PIN_W-1:0] bidir_out, // spike, count
  input wire logic [PIN_W-1:0] bidir_oe // enables
);
  // all checks share one domain and sleep through reset
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (srst);
  a_oe_fixed: assert property (bidir_oe == OE_VALUE) else $error("enables wrong");
  a_refr_span: assert property (bidir_out[SPIKE_BIT] |-> dedicated_out[REFR_BIT] [*3])
    else $error("refractory short");
  a_no_refire: assert property (bidir_out[SPIKE_BIT] |=> !bidir_out[SPIKE_BIT] [*2])
    else $error("fired while refractory");
  a_spike_clear: assert property (bidir_out[SPIKE_BIT] |-> dedicated_out[6:0] == 7'h00)
    else $error("potential kept");
  a_count_step: assert property (bidir_out[SPIKE_BIT] |-> bidir_out[6:0] == 7'($past(bidir_out[6:0]) + 7'h01))
    else $error("count step");
  a_count_hold: assert property (!bidir_out[SPIKE_BIT] |-> $stable(bidir_out[6:0]))
    else $error("count moved");
  a_refr_cause: assert property ($rose(dedicated_out[REFR_BIT]) |-> bidir_out[SPIKE_BIT])
    else $error("refractory without spike");
  a_refr_quiet: assert property (dedicated_out[REFR_BIT] |-> dedicated_out[6:0] == 7'h00)
    else $error("integrating while refractory");
endmodule
bind asn_neuron asn_checker i_chk (.core_clk(core_clk), .srst(srst), .neuron_current_in(neuron_current_in),
  .bidir_in(bidir_in), .dedicated_out(dedicated_out), .bidir_out(bidir_out), .bidir_oe(bidir_oe));
`default_nettype wire

// file: tb/asn_neuron_tb.sv
// self-checking bench for the adaptive spiking neuron
`timescale 1ns/1ps
`default_nettype none
module asn_neuron_tb
  import asn_pkg::*;
;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [CUR_W-1:0] level = 8'h00;
  logic learn = 1'b0;
  wire logic [CUR_W-1:0] cur;
  wire logic [PIN_W-1:0] bin, dout, bout, boe;
  int errors = 0;
  int tests_run = 0;
  int n;
  initial
  begin
    forever #12.5 core_clk = ~core_clk;
  end
  asn_stim i_stim (.level(level), .learn(learn), .bidir_out(bout), .bidir_oe(boe), .neuron_current_in(cur),
    .bidir_in(bin));
  asn_neuron i_dut (.core_clk(core_clk), .srst(srst), .neuron_current_in(cur), .bidir_in(bin),
    .dedicated_out(dout), .bidir_out(bout), .bidir_oe(boe));
  // inputs move 1 ns after the edge so sampling never races
  task automatic step(input int k);
    repeat (k) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      errors++;
    end
  endtask
  // current set before release: the synchroniser makes edge 3 the first to use it
  task automatic rst_with(input logic [7:0] c);
    level = c;
    srst = 1'b1;
    step(3);
    srst = 1'b0;
  endtask
  task automatic count(input int k);
    n = 0;
    repeat (k)
    begin
      step(1);
      n += int'(bout[SPIKE_BIT]);
    end
  endtask
  task automatic t_edge;
    rst_with(8'd99);
    chk("pot", 8'h00, dout);
    chk("spk", 8'h00, bout);
    chk("oe", 8'hFE, boe);
    step(3);
    chk("pot", 8'h63, dout);
    step(1);
    chk("pot", 8'h80, dout);
    chk("spk", 8'h81, bout);
    $display("threshold edge done");
  endtask
  task automatic t_leak;
    rst_with(8'd20);
    step(40);
    chk("pot", 8'h50, dout);
    chk("spk", 8'h00, bout);
    $display("leak done");
  endtask
  task automatic t_period;
    rst_with(8'd100);
    step(3);
    chk("spk", 8'h81, bout);
    count(520);
    chk("spikes", 8'h82, 8'(n));
    chk("spk", 8'h83, bout);
    $display("period and wrap done");
  endtask
  task automatic t_learn;
    learn = 1'b1;
    count(400);
    chk("slowed", 8'h01, 8'(n < 100));
    level = 8'd0;
    step(300);
    level = 8'd100;
    step(3);
    chk("refire", 8'h01, 8'(bout[SPIKE_BIT]));
    learn = 1'b0;
    $display("learning done");
  endtask
  // strong drive with learning raises the threshold above base; reset must bring it back to 100
  task automatic t_adapt_reset;
    level = 8'd200;
    learn = 1'b1;
    step(40);
    learn = 1'b0;
    rst_with(8'd100);
    step(3);
    chk("spk", 8'h81, bout);
    $display("adaptation reset done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    t_edge();
    t_leak();
    t_period();
    t_learn();
    t_adapt_reset();
    stop_test();
  end
endmodule
`default_nettype wire

// file: tb/asn_stim.sv
// stimulus source: current pins and the shared learning pin
`timescale 1ns/1ps
`default_nettype none
module asn_stim
  import asn_pkg::*;
(
  input wire logic [CUR_W-1:0] level, // wanted current
  input wire logic learn, // wanted learning mode
  input wire logic [PIN_W-1:0] bidir_out, // device drive
  input wire logic [PIN_W-1:0] bidir_oe, // device enables
  output logic [CUR_W-1:0] neuron_current_in, // current pins
  output logic [PIN_W-1:0] bidir_in // resolved pins
);
  // source drives pin 0 only where the device leaves it free
  assign neuron_current_in = level;
  assign bidir_in = (bidir_oe & bidir_out) | (~bidir_oe & {7'h00, learn});
endmodule
`default_nettype wire
